// >>> afd_defs.vh
// Register map, field positions and reset values for the filter, stamp and timestamp control bank
`ifndef AFD_DEFS_VH
`define AFD_DEFS_VH
`define AFD_ADDR_FILTER_CTRL 8'h17
`define AFD_ADDR_STAMP_CTRL 8'h18
`define AFD_ADDR_COUNTER_CTRL 8'h19
`define AFD_ADDR_INT_SUMMARY 8'h1a
`define AFD_ADDR_TS0 8'h40
`define AFD_ADDR_TS1 8'h41
`define AFD_ADDR_TS2 8'h42
`define AFD_ADDR_TS3 8'h43
// Filter control fields
`define AFD_F_CUTOFF 7:5
`define AFD_F_HPREF 4
`define AFD_F_FASTSET 3
`define AFD_F_SLOPE 2
`define AFD_F_ORIENT 0
`define AFD_FILTER_WMASK 8'hfd
`define AFD_FILTER_RST 8'h00
// Stamp control fields
`define AFD_S_X 7
`define AFD_S_Y 6
`define AFD_S_Z 5
`define AFD_S_SENSOR 4
`define AFD_S_XLEXT 3
`define AFD_S_POL 2
`define AFD_S_CONF 1
`define AFD_STAMP_WMASK 8'hfe
`define AFD_STAMP_RST 8'he0
// Counter control fields
`define AFD_C_TSEN 5
`define AFD_COUNTER_WMASK 8'h20
`define AFD_COUNTER_RST 8'h00
// Interrupt summary fields
`define AFD_I_ENDCNT 7
`define AFD_I_ACT 5
`define AFD_I_ORIENT 4
`define AFD_I_DTAP 3
`define AFD_I_STAP 2
`define AFD_I_WAKE 1
`define AFD_I_FFALL 0
// Bandwidth select encodings for the accelerometer path
`define AFD_BW_HALF 4'h0
`define AFD_BW_SLOPE 4'h1
`define AFD_BW_DIV 4'h8
// Trigger modes edge, level, latch, FIFO
`define AFD_TRIG_EDGE 3'h4
`define AFD_TRIG_LEVEL 3'h2
`define AFD_TRIG_LATCH 3'h3
`define AFD_TRIG_FIFO 3'h6
// Overflow warning lead time in microseconds
`define AFD_WARN_US 6400
`define AFD_CLK_MHZ 25
// Sample strobes that fast settling stays active after power-down exit
`define AFD_SETTLE_SAMPLES 2'h2
`endif

// >>> afd_stamp_sync.v
// Two-stage synchroniser and polarity handling for the external stamp pin
`default_nettype none
module afd_stamp_sync (
    input wire i_ref_clk,
    input wire i_rst,
    input wire i_ce,
    input wire i_pin,
    input wire i_polarity,
    output reg o_active
);
    reg meta_reg;
    reg sync_reg;
    // Two flops before any logic, then polarity applied
    always @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            o_active <= 1'b0;
        end else if (i_ce) begin
            meta_reg <= i_pin;
            sync_reg <= meta_reg;
            o_active <= i_polarity ? sync_reg : ~sync_reg;
        end
    end
endmodule // afd_stamp_sync
`default_nettype wire

// >>> afd_regs.v
// Accelerometer filter, stamp pin and timestamp control register bank
// Overview of operation
// - SECOND_LOWPASS_STAGE on, low-pass path: cutoff code 000..111 selects rate/4 through rate/800.
// - Slope/high-pass bit routes high-pass path; code 000 is slope at rate/4.
// - Low-pass path with SECOND_LOWPASS_STAGE off gives half-rate bandwidth, cutoff ignored.
// - High-pass reference enable, reset 0, acts only with high-pass path selected.
// - Fast-settle, reset 0, settles by second sample; acts on power-down exit.
// - Orientation source 0 feeds half-rate data, 1 feeds SECOND_LOWPASS_STAGE output.
// - Per-axis stamp enables, reset 1, put pin value in axis LSB.
// - Sensor select 0 stamps gyroscope axes, 1 stamps accelerometer axes.
// - Separate enable, reset 0, extends stamp function to accelerometer.
// - Pin active low when polarity 0, active high when 1.
// - Timestamp enable runs counter; count readable at 40h through 43h.
// - End-count flag warns counter overflows within 6.4 ms.
// - Read-only summary reports activity, orientation, taps, wake-up, free-fall.
// - First stage cuts at rate/2 high-performance up to 833 Hz, else 780 Hz.
// - Trigger bits 100 edge, 010 level, 011 latched, 110 FIFO enable.
// - Stamp data-ready high for data from active pin; latched or pulsed.
`default_nettype none
`include "afd_defs.vh"
module afd_regs #(
    parameter TS_WIDTH = 32,
    parameter WARN_CYCLES = `AFD_WARN_US * `AFD_CLK_MHZ
) (
    input wire i_ref_clk,
    input wire i_rst,
    input wire i_ce,
    input wire i_wr_en,
    input wire i_rd_en,
    input wire [7:0] i_addr,
    input wire [7:0] i_wdata,
    input wire i_stamp_pin,
    input wire [2:0] i_trig_mode,
    input wire i_drdy_pulsed,
    input wire i_sample_strobe,
    input wire i_power_down,
    input wire i_high_perf,
    input wire [15:0] i_gyro_x,
    input wire [15:0] i_gyro_y,
    input wire [15:0] i_gyro_z,
    input wire [15:0] i_accel_x,
    input wire [15:0] i_accel_y,
    input wire [15:0] i_accel_z,
    input wire i_activity_change_flag,
    input wire i_orientation_change_flag,
    input wire i_double_tap_flag,
    input wire i_single_tap_flag,
    input wire i_wakeup_event_flag,
    input wire i_freefall_event_flag,
    output reg [7:0] o_rdata,
    output reg o_rvalid,
    output reg [3:0] o_accel_bw_sel,
    output reg [2:0] o_accel_bw_code,
    output reg o_first_lowpass_stage_half_rate,
    output reg o_highpass_reference_enable,
    output reg o_fast_settle_active,
    output reg o_orientation_second_lowpass_stage,
    output reg o_proper_config_enable,
    output reg [15:0] o_gyro_x,
    output reg [15:0] o_gyro_y,
    output reg [15:0] o_gyro_z,
    output reg [15:0] o_accel_x,
    output reg [15:0] o_accel_y,
    output reg [15:0] o_accel_z,
    output reg o_stamp_data_ready
);
    localparam [TS_WIDTH-1:0] TS_MAX = {TS_WIDTH{1'b1}};
    localparam [TS_WIDTH-1:0] TS_WARN_AT = TS_MAX - WARN_CYCLES[TS_WIDTH-1:0];
    reg [7:0] filter_ctrl_reg;
    reg [7:0] stamp_ctrl_reg;
    reg [7:0] counter_ctrl_reg;
    reg [TS_WIDTH-1:0] ts_count_reg;
    reg [1:0] settle_cnt_reg;
    reg power_down_d_reg;
    reg pd_meta_reg;
    reg pd_sync_reg;
    reg hp_meta_reg;
    reg hp_sync_reg;
    reg pin_active_d_reg;
    reg trig_latch_reg;
    wire pin_active;
    wire second_lowpass_enable;
    wire [2:0] accel_cutoff_code;
    wire slope_highpass_select;
    wire stamp_accel;
    wire stamp_gyro;
    wire den_cond;
    wire [7:0] int_summary;
    reg [7:0] rdata_next;
    reg [3:0] bw_sel_next;
    reg den_next;
    reg [31:0] ts_word;

    afd_stamp_sync u_sync (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_ce(i_ce),
        .i_pin(i_stamp_pin),
        .i_polarity(stamp_ctrl_reg[`AFD_S_POL]),
        .o_active(pin_active)
    );

    assign accel_cutoff_code = filter_ctrl_reg[`AFD_F_CUTOFF];
    assign slope_highpass_select = filter_ctrl_reg[`AFD_F_SLOPE];
    // SECOND_LOWPASS_STAGE counts as enabled whenever the orientation bit is set or a nonzero cutoff code is programmed
    assign second_lowpass_enable = filter_ctrl_reg[`AFD_F_ORIENT] | (accel_cutoff_code != 3'h0);
    assign stamp_accel = stamp_ctrl_reg[`AFD_S_SENSOR] | stamp_ctrl_reg[`AFD_S_XLEXT];
    assign stamp_gyro = ~stamp_ctrl_reg[`AFD_S_SENSOR];

    // Trigger mode decides when the pin condition qualifies data
    always @* begin
        case (i_trig_mode)
            `AFD_TRIG_EDGE: den_next = pin_active & ~pin_active_d_reg;
            `AFD_TRIG_LEVEL: den_next = pin_active;
            `AFD_TRIG_LATCH: den_next = trig_latch_reg;
            `AFD_TRIG_FIFO: den_next = pin_active;
            default: den_next = 1'b0;
        endcase
    end
    assign den_cond = den_next;

    // Bandwidth path selection
    always @* begin
        if (slope_highpass_select) begin
            bw_sel_next = (accel_cutoff_code == 3'h0) ? `AFD_BW_SLOPE : `AFD_BW_DIV;
        end else if (second_lowpass_enable) begin
            bw_sel_next = `AFD_BW_DIV;
        end else begin
            bw_sel_next = `AFD_BW_HALF;
        end
    end

    // Summary of embedded-function flags, live from the detectors
    assign int_summary = {(ts_count_reg >= TS_WARN_AT) & counter_ctrl_reg[`AFD_C_TSEN], 1'b0,
        i_activity_change_flag, i_orientation_change_flag, i_double_tap_flag,
        i_single_tap_flag, i_wakeup_event_flag, i_freefall_event_flag};

    // Counter widened to the four readable bytes so a short counter reads zero above its top
    always @* begin
        ts_word = 32'h0000_0000;
        ts_word[TS_WIDTH-1:0] = ts_count_reg;
    end

    // Read decode
    always @* begin
        if (i_addr == `AFD_ADDR_FILTER_CTRL) begin
            rdata_next = filter_ctrl_reg;
        end else if (i_addr == `AFD_ADDR_STAMP_CTRL) begin
            rdata_next = stamp_ctrl_reg;
        end else if (i_addr == `AFD_ADDR_COUNTER_CTRL) begin
            rdata_next = counter_ctrl_reg;
        end else if (i_addr == `AFD_ADDR_INT_SUMMARY) begin
            rdata_next = int_summary;
        end else if (i_addr == `AFD_ADDR_TS0) begin
            rdata_next = ts_word[7:0];
        end else if (i_addr == `AFD_ADDR_TS1) begin
            rdata_next = ts_word[15:8];
        end else if (i_addr == `AFD_ADDR_TS2) begin
            rdata_next = ts_word[23:16];
        end else if (i_addr == `AFD_ADDR_TS3) begin
            rdata_next = ts_word[31:24];
        end else begin
            rdata_next = 8'h00;
        end
    end

    // Register writes; fixed-zero bits are held at zero by the masks
    always @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            filter_ctrl_reg <= `AFD_FILTER_RST;
            stamp_ctrl_reg <= `AFD_STAMP_RST;
            counter_ctrl_reg <= `AFD_COUNTER_RST;
            o_rdata <= 8'h00;
            o_rvalid <= 1'b0;
        end else if (i_ce) begin
            o_rvalid <= i_rd_en;
            if (i_rd_en) begin
                o_rdata <= rdata_next;
            end
            if (i_wr_en) begin
                if (i_addr == `AFD_ADDR_FILTER_CTRL) begin
                    filter_ctrl_reg <= i_wdata & `AFD_FILTER_WMASK;
                end else if (i_addr == `AFD_ADDR_STAMP_CTRL) begin
                    stamp_ctrl_reg <= i_wdata & `AFD_STAMP_WMASK;
                end else if (i_addr == `AFD_ADDR_COUNTER_CTRL) begin
                    counter_ctrl_reg <= i_wdata & `AFD_COUNTER_WMASK;
                end
            end
        end
    end

    // Timestamp counter
    always @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            ts_count_reg <= {TS_WIDTH{1'b0}};
        end else if (i_ce) begin
            if (counter_ctrl_reg[`AFD_C_TSEN]) begin
                ts_count_reg <= ts_count_reg + {{(TS_WIDTH-1){1'b0}}, 1'b1};
            end
        end
    end

    // Power-down and mode inputs synchronised; fast settle on power-down exit
    always @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            pd_meta_reg <= 1'b1;
            pd_sync_reg <= 1'b1;
            power_down_d_reg <= 1'b1;
            hp_meta_reg <= 1'b0;
            hp_sync_reg <= 1'b0;
            settle_cnt_reg <= 2'h0;
            o_fast_settle_active <= 1'b0;
        end else if (i_ce) begin
            pd_meta_reg <= i_power_down;
            pd_sync_reg <= pd_meta_reg;
            power_down_d_reg <= pd_sync_reg;
            hp_meta_reg <= i_high_perf;
            hp_sync_reg <= hp_meta_reg;
            if (power_down_d_reg & ~pd_sync_reg & filter_ctrl_reg[`AFD_F_FASTSET]) begin
                settle_cnt_reg <= `AFD_SETTLE_SAMPLES;
                o_fast_settle_active <= 1'b1;
            end else if (settle_cnt_reg != 2'h0 && i_sample_strobe) begin
                settle_cnt_reg <= settle_cnt_reg - 2'h1;
                o_fast_settle_active <= (settle_cnt_reg != 2'h1);
            end
        end
    end

    // Filter control outputs
    always @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_accel_bw_sel <= `AFD_BW_HALF;
            o_accel_bw_code <= 3'h0;
            o_first_lowpass_stage_half_rate <= 1'b0;
            o_highpass_reference_enable <= 1'b0;
            o_orientation_second_lowpass_stage <= 1'b0;
            o_proper_config_enable <= 1'b0;
        end else if (i_ce) begin
            o_accel_bw_sel <= bw_sel_next;
            o_accel_bw_code <= accel_cutoff_code;
            o_first_lowpass_stage_half_rate <= hp_sync_reg;
            o_highpass_reference_enable <= filter_ctrl_reg[`AFD_F_HPREF] & slope_highpass_select;
            o_orientation_second_lowpass_stage <= filter_ctrl_reg[`AFD_F_ORIENT];
            o_proper_config_enable <= stamp_ctrl_reg[`AFD_S_CONF];
        end
    end

    // Stamp the pin condition into axis LSBs and flag qualified data
    always @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            pin_active_d_reg <= 1'b0;
            trig_latch_reg <= 1'b0;
            o_gyro_x <= 16'h0000;
            o_gyro_y <= 16'h0000;
            o_gyro_z <= 16'h0000;
            o_accel_x <= 16'h0000;
            o_accel_y <= 16'h0000;
            o_accel_z <= 16'h0000;
            o_stamp_data_ready <= 1'b0;
        end else if (i_ce) begin
            pin_active_d_reg <= pin_active;
            if (pin_active & ~pin_active_d_reg) begin
                trig_latch_reg <= 1'b1;
            end else if (i_sample_strobe) begin
                trig_latch_reg <= 1'b0;
            end
            if (i_sample_strobe) begin
                o_gyro_x <= {i_gyro_x[15:1], (stamp_gyro & stamp_ctrl_reg[`AFD_S_X]) ? den_cond : i_gyro_x[0]};
                o_gyro_y <= {i_gyro_y[15:1], (stamp_gyro & stamp_ctrl_reg[`AFD_S_Y]) ? den_cond : i_gyro_y[0]};
                o_gyro_z <= {i_gyro_z[15:1], (stamp_gyro & stamp_ctrl_reg[`AFD_S_Z]) ? den_cond : i_gyro_z[0]};
                o_accel_x <= {i_accel_x[15:1], (stamp_accel & stamp_ctrl_reg[`AFD_S_X]) ? den_cond : i_accel_x[0]};
                o_accel_y <= {i_accel_y[15:1], (stamp_accel & stamp_ctrl_reg[`AFD_S_Y]) ? den_cond : i_accel_y[0]};
                o_accel_z <= {i_accel_z[15:1], (stamp_accel & stamp_ctrl_reg[`AFD_S_Z]) ? den_cond : i_accel_z[0]};
                o_stamp_data_ready <= den_cond;
            end else if (i_drdy_pulsed) begin
                o_stamp_data_ready <= 1'b0;
            end
        end
    end
endmodule // afd_regs
`default_nettype wire

// >>> afd_regs_props.sv
// Assertions on the filter, stamp and timestamp register bank ports
`default_nettype none
module afd_regs_props #(
    parameter TS_WIDTH = 32,
    parameter WARN_CYCLES = 160000
) (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic i_wr_en,
    input wire logic i_rd_en,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_sample_strobe,
    input wire logic i_high_perf,
    input wire logic [15:0] i_gyro_x,
    input wire logic o_rvalid,
    input wire logic [3:0] o_accel_bw_sel,
    input wire logic [2:0] o_accel_bw_code,
    input wire logic o_first_lowpass_stage_half_rate,
    input wire logic o_highpass_reference_enable,
    input wire logic o_orientation_second_lowpass_stage,
    input wire logic o_proper_config_enable,
    input wire logic [15:0] o_gyro_x
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    // Accepted writes to the filter and stamp registers
    wire logic w17 = i_ce && i_wr_en && i_addr == 8'h17;
    wire logic w18 = i_ce && i_wr_en && i_addr == 8'h18;
    AST_READ_ANSWER: assert property (i_ce && i_rd_en |=> o_rvalid)
        else $error("read not answered");
    AST_ANSWER_CAUSE: assert property (o_rvalid |-> $past(i_ce && i_rd_en))
        else $error("answer without read");
    // Control outputs are registered from the control register, so they show a write two edges later
    AST_BW_LOWPASS: assert property (w17 && !i_wdata[2] && (i_wdata[0] || i_wdata[7:5] != 3'h0) |-> ##2
        o_accel_bw_sel == 4'h8 && o_accel_bw_code == $past(i_wdata[7:5], 2)) else $error("low-pass cutoff wrong");
    AST_BW_HALF: assert property (w17 && i_wdata[7:5] == 3'h0 && !i_wdata[2] && !i_wdata[0] |-> ##2
        o_accel_bw_sel == 4'h0) else $error("half-rate bandwidth wrong");
    AST_BW_HIGHPASS: assert property (w17 && i_wdata[2] |-> ##2
        o_accel_bw_sel == (($past(i_wdata[7:5], 2) == 3'h0) ? 4'h1 : 4'h8)) else $error("high-pass select wrong");
    AST_HPREF_GATED: assert property (w17 |-> ##2 o_highpass_reference_enable == $past(i_wdata[4] && i_wdata[2], 2))
        else $error("reference mode gating wrong");
    AST_ORIENT_SRC: assert property (w17 |-> ##2 o_orientation_second_lowpass_stage == $past(i_wdata[0], 2))
        else $error("orientation source wrong");
    AST_CONFIG_BIT: assert property (w18 |-> ##2 o_proper_config_enable == $past(i_wdata[1], 2))
        else $error("config enable wrong");
    AST_HALF_RATE_HP: assert property ((i_ce && i_high_perf) [*5] |-> o_first_lowpass_stage_half_rate)
        else $error("first stage not half rate");
    AST_LOW_POWER_CUT: assert property ((i_ce && !i_high_perf) [*5] |-> !o_first_lowpass_stage_half_rate)
        else $error("first stage not fixed cutoff");
    AST_UPPER_BITS_KEPT: assert property (i_ce && i_sample_strobe |=>
        o_gyro_x[15:1] == $past(i_gyro_x[15:1])) else $error("sample upper bits altered");
endmodule // afd_regs_props
bind afd_regs afd_regs_props #(.TS_WIDTH(TS_WIDTH), .WARN_CYCLES(WARN_CYCLES)) u_props (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_ce(i_ce), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_sample_strobe(i_sample_strobe), .i_high_perf(i_high_perf),
    .i_gyro_x(i_gyro_x), .o_rvalid(o_rvalid), .o_accel_bw_sel(o_accel_bw_sel),
    .o_accel_bw_code(o_accel_bw_code), .o_first_lowpass_stage_half_rate(o_first_lowpass_stage_half_rate),
    .o_highpass_reference_enable(o_highpass_reference_enable), .o_orientation_second_lowpass_stage(o_orientation_second_lowpass_stage),
    .o_proper_config_enable(o_proper_config_enable), .o_gyro_x(o_gyro_x));
`default_nettype wire

// >>> afd_host_model.sv
// Host controller model driving the register request port
`default_nettype none
module afd_host_model (
    input wire logic i_ref_clk,
    input wire logic [7:0] i_rdata,
    input wire logic i_rvalid,
    output logic o_wr_en,
    output logic o_rd_en,
    output logic [7:0] o_addr,
    output logic [7:0] o_wdata
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle bus after reset
    initial begin
        o_wr_en = 1'b0;
        o_rd_en = 1'b0;
        o_addr = 8'h00;
        o_wdata = 8'h00;
    end
    // One-cycle write; callers keep fixed-zero bits clear, except the FFh write to read-only 1Ah
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_ref_clk);
        o_wr_en = 1'b1;
        o_addr = a;
        o_wdata = d;
        @(negedge i_ref_clk);
        o_wr_en = 1'b0;
        o_wdata = ~d;
    endtask
    // One-cycle read; data taken while the answer stands
    task rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge i_ref_clk);
        o_rd_en = 1'b1;
        o_addr = a;
        @(negedge i_ref_clk);
        o_rd_en = 1'b0;
        o_addr = ~a;
        d = (i_rvalid === 1'b1) ? i_rdata : 8'hxx;
    endtask
endmodule // afd_host_model
`default_nettype wire

// >>> accel_filter_den_timestamp_regs_bench.sv
// Self-checking bench for the filter, stamp and timestamp register bank
`default_nettype none
module accel_filter_den_timestamp_regs_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_ref_clk, i_rst, pin, strobe, pdown, hperf, pulsed;
    logic [2:0] trig;
    logic [5:0] flags;
    logic [15:0] gx, gy, gz, ax, ay, az;
    logic [7:0] v, d;
    logic a;
    int mismatches, cmp_count, n;
    wire logic wr_en, rd_en, rvalid, half, hpref, fset, orient, conf, drdy;
    wire logic [7:0] addr, wdata, rdata;
    wire logic [3:0] bw_sel;
    wire logic [2:0] bw_code;
    wire logic [15:0] ogx, ogy, ogz, oax, oay, oaz;
    afd_host_model host (.i_ref_clk(i_ref_clk), .i_rdata(rdata), .i_rvalid(rvalid), .o_wr_en(wr_en),
        .o_rd_en(rd_en), .o_addr(addr), .o_wdata(wdata));
    afd_regs #(.TS_WIDTH(8), .WARN_CYCLES(16)) uut (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_ce(1'b1),
        .i_wr_en(wr_en), .i_rd_en(rd_en), .i_addr(addr), .i_wdata(wdata), .i_stamp_pin(pin),
        .i_trig_mode(trig), .i_drdy_pulsed(pulsed), .i_sample_strobe(strobe), .i_power_down(pdown),
        .i_high_perf(hperf), .i_gyro_x(gx), .i_gyro_y(gy), .i_gyro_z(gz), .i_accel_x(ax), .i_accel_y(ay),
        .i_accel_z(az), .i_activity_change_flag(flags[5]), .i_orientation_change_flag(flags[4]),
        .i_double_tap_flag(flags[3]), .i_single_tap_flag(flags[2]), .i_wakeup_event_flag(flags[1]),
        .i_freefall_event_flag(flags[0]), .o_rdata(rdata), .o_rvalid(rvalid), .o_accel_bw_sel(bw_sel),
        .o_accel_bw_code(bw_code), .o_first_lowpass_stage_half_rate(half), .o_highpass_reference_enable(hpref),
        .o_fast_settle_active(fset), .o_orientation_second_lowpass_stage(orient), .o_proper_config_enable(conf),
        .o_gyro_x(ogx), .o_gyro_y(ogy), .o_gyro_z(ogz), .o_accel_x(oax), .o_accel_y(oay), .o_accel_z(oaz),
        .o_stamp_data_ready(drdy));
    // Free-running reference clock
    initial begin
        i_ref_clk = 1'b0;
        forever #20 i_ref_clk = ~i_ref_clk;
    end
    task give_verdict();
        if (mismatches == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            mismatches++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task rchk(input logic [7:0] ad, input logic [7:0] e);
        host.rd(ad, d);
        chk("rdata", {8'h00, e}, {8'h00, d});
    endtask
    // Expected bandwidth select for a filter register value
    function automatic logic [3:0] bw_exp(input logic [7:0] f);
        if (f[2]) return (f[7:5] == 3'h0) ? 4'h1 : 4'h8;
        return (f[0] || f[7:5] != 3'h0) ? 4'h8 : 4'h0;
    endfunction
    function automatic logic [15:0] stamp(input logic [15:0] r, input logic en);
        return en ? {r[15:1], a} : r;
    endfunction
    task settle(input int c);
        repeat (c) @(negedge i_ref_clk);
    endtask
    // Main sequence
    initial begin
        i_rst = 1'b1;
        pin = 1'b0;
        strobe = 1'b0;
        pdown = 1'b0;
        hperf = 1'b1;
        pulsed = 1'b0;
        trig = 3'h2;
        flags = 6'h00;
        {gx, gy, gz, ax, ay, az} = '0;
        void'($urandom(78));
        settle(5);
        i_rst = 1'b0;
        rchk(8'h17, 8'h00);
        rchk(8'h18, 8'he0);
        rchk(8'h19, 8'h00);
        rchk(8'h55, 8'h00);
        for (int i = 0; i < 12; i++) begin
            v = (i < 4) ? 8'h00 + 8'(i == 1) * 8'h04 + 8'(i == 2) * 8'h01 + 8'(i == 3) * 8'h14 : 8'($urandom());
            v = v & 8'hfd;
            host.wr(8'h17, v);
            rchk(8'h17, v);
            chk("bw_sel", 16'(bw_exp(v)), 16'(bw_sel));
            if (bw_exp(v) == 4'h8) chk("bw_code", 16'(v[7:5]), 16'(bw_code));
            chk("hpref", 16'(v[4] & v[2]), 16'(hpref));
            chk("orient", 16'(v[0]), 16'(orient));
            hperf = i[0];
        end
        host.wr(8'h17, 8'h14);
        // Host throws away the first sample after enabling reference mode
        strobe = 1'b1;
        settle(1);
        strobe = 1'b0;
        settle(2);
        chk("half_rate", 16'(hperf), 16'(half));
        for (int i = 0; i < 8; i++) begin
            v = {8'($urandom()) & 8'hfc} | 8'h02;
            host.wr(8'h18, v);
            pin = 1'($urandom());
            a = v[2] ? pin : ~pin;
            settle(4);
            {gx, gy, gz, ax, ay, az} = {$urandom(), $urandom(), $urandom()};
            strobe = 1'b1;
            settle(1);
            strobe = 1'b0;
            settle(1);
            chk("gyro_x", stamp(gx, !v[4] && v[7]), ogx);
            chk("gyro_y", stamp(gy, !v[4] && v[6]), ogy);
            chk("gyro_z", stamp(gz, !v[4] && v[5]), ogz);
            chk("accel_x", stamp(ax, (v[4] || v[3]) && v[7]), oax);
            chk("accel_y", stamp(ay, (v[4] || v[3]) && v[6]), oay);
            chk("accel_z", stamp(az, (v[4] || v[3]) && v[5]), oaz);
        end
        host.wr(8'h18, 8'he6);
        for (int i = 0; i < 4; i++) begin
            trig = (i == 0) ? 3'h4 : (i == 1) ? 3'h2 : (i == 2) ? 3'h3 : 3'h6;
            pulsed = i[0];
            pin = 1'b0;
            settle(4);
            strobe = 1'b1;
            settle(1);
            strobe = 1'b0;
            chk("data_ready_idle", 16'h0, 16'(drdy));
            pin = 1'b1;
            // Edge mode qualifies only the sample taken in the cycle the edge is seen
            settle((i == 0) ? 3 : 4);
            strobe = 1'b1;
            settle(1);
            strobe = 1'b0;
            chk("data_ready", 16'h1, 16'(drdy));
            settle(1);
            chk("data_ready_hold", 16'(!pulsed), 16'(drdy));
        end
        host.wr(8'h17, 8'h08);
        pdown = 1'b1;
        settle(4);
        pdown = 1'b0;
        settle(5);
        chk("fast_settle", 16'h1, 16'(fset));
        for (int i = 0; i < 2; i++) begin
            strobe = 1'b1;
            settle(1);
            strobe = 1'b0;
            settle(1);
            chk("fast_settle", 16'(i == 0), 16'(fset));
        end
        flags = 6'($urandom());
        host.wr(8'h1a, 8'hff);
        settle(3);
        rchk(8'h1a, {2'b00, flags});
        host.wr(8'h19, 8'h20);
        rchk(8'h19, 8'h20);
        d = 8'h00;
        n = 0;
        while (d[7] !== 1'b1 && n < 300) begin
            host.rd(8'h1a, d);
            n++;
        end
        if (n >= 300) begin
            mismatches++;
        end else begin
            chk("endcount_early", 16'h1, 16'(n > 1));
            host.rd(8'h40, d);
            chk("ts_low", 16'h1, 16'(d >= 8'hef));
            rchk(8'h41, 8'h00);
        end
        give_verdict();
    end
endmodule // accel_filter_den_timestamp_regs_bench
`default_nettype wire
